// ---- odt_pkg.sv ----
package odt_pkg;

    // avalon register map, byte addresses
    localparam int             AVS_AW         = 8;
    localparam logic [7:0]     OFS_HDR0       = 8'h00;
    localparam logic [7:0]     OFS_HDR1       = 8'h04;
    localparam logic [7:0]     OFS_STAT       = 8'h08;
    localparam logic [7:0]     OFS_MASK       = 8'h0c;
    localparam logic [7:0]     OFS_TBL        = 8'h20;
    localparam int             TBL_SEL_LSB    = 5;

    // table geometry: four entries of two dwords
    localparam int             TBL_DW         = 8;
    localparam int             TBL_AW         = 3;
    localparam int             NUM_SEQ        = 4;
    localparam int             MASK_W         = 7;
    localparam logic [7:0]     MAX_LEN        = 8'h07;

    // header field values
    localparam logic [7:0]     HDR_ID_LSB     = 8'h0a;
    localparam logic [7:0]     HDR_ID_MSB     = 8'hff;
    localparam logic [7:0]     HDR_MAJOR      = 8'h01;
    localparam logic [7:0]     HDR_MINOR      = 8'h00;
    localparam logic [7:0]     HDR_TBL_LEN    = 8'h08;

    // field positions inside an entry and the second header dword
    localparam int             LEN_LSB        = 24;
    localparam int             ID_MSB_LSB     = 24;
    localparam int             PTR_W          = 24;
    localparam logic [23:0]    PTR_RST        = 24'h000080;

    // status register layout
    localparam int             STAT_PRES_LSB  = 0;
    localparam int             STAT_BAD_LSB   = 4;
    localparam int             STAT_ALIGN_BIT = 8;

    // which of the seven sequence bytes a count covers, bit 0 is byte 1
    function automatic logic [6:0] byte_mask(input logic [7:0] len);
        logic [6:0] m;
        m = 7'h00;
        for (int i = 0; i < MASK_W; i++) begin
            m[i] = (len > 8'(i));
        end
        return m;
    endfunction : byte_mask

endpackage : odt_pkg

// ---- odt_table_mem.sv ----
module odt_table_mem (
    // clock
    input  wire logic                           sys_clk_in,
    // write port
    input  wire logic                           we_in,
    input  wire logic [3:0]                     be_in,
    input  wire logic [31:0]                    wdata_in,
    // shared address, registered read data
    input  wire logic [odt_pkg::TBL_AW-1:0]     addr_in,
    output logic      [31:0]                    rdata_out
);

    logic [31:0] mem_r [odt_pkg::TBL_DW];

    // byte-lane write and registered read
    always_ff @(posedge sys_clk_in) begin
        for (int b = 0; b < 4; b++) begin
            if (we_in && be_in[b]) begin
                mem_r[addr_in][b*8 +: 8] <= wdata_in[b*8 +: 8];
            end
        end
        rdata_out <= mem_r[addr_in];
    end

endmodule : odt_table_mem

// ---- odt_seq_check.sv ----
module odt_seq_check (
    // length byte of one entry
    input  wire logic [7:0]                     len_in,
    // decoded view of the entry
    output logic                                present_out,
    output logic                                bad_len_out,
    output logic [odt_pkg::MASK_W-1:0]          byte_mask_out
);

    // zero means absent, above seven is out of range
    assign present_out   = (len_in != 8'h00);
    assign bad_len_out   = (len_in > odt_pkg::MAX_LEN);
    assign byte_mask_out = odt_pkg::byte_mask(len_in);

endmodule : odt_seq_check

// ---- odt_seq_table.sv ----
// Function
// - header dword two top byte reads FFh
// - table pointer is a dword-aligned byte address
// - entry top byte is count, zero means absent
// - bytes 1-3 sit in first dword
// - bytes 4-7 sit in second dword
// - four two-dword entries in ascending order
// - header dword one low byte reads 0Ah
module odt_seq_table (
    // clock and reset
    input  wire logic                           sys_clk_in,
    input  wire logic                           sys_rst_in,
    // avalon-mm slave
    input  wire logic [odt_pkg::AVS_AW-1:0]     avs_address_in,
    input  wire logic                           avs_read_in,
    input  wire logic                           avs_write_in,
    input  wire logic [31:0]                    avs_writedata_in,
    input  wire logic [3:0]                     avs_byteenable_in,
    output logic      [31:0]                    avs_readdata_out,
    output logic                                avs_waitrequest_out,
    // parameter-space read port
    input  wire logic                           prm_rd_in,
    input  wire logic [odt_pkg::PTR_W-1:0]      prm_addr_in,
    output logic      [31:0]                    prm_data_out,
    output logic                                prm_valid_out,
    // status pins
    output logic      [odt_pkg::PTR_W-1:0]      table_start_pointer_out,
    output logic      [odt_pkg::NUM_SEQ-1:0]    seq_present_out
);

    typedef enum logic [1:0] {ST_IDLE, ST_BUS_RD, ST_PRM_RD, ST_ACK} odt_state_t;

    odt_state_t                         st_r, st_nxt;
    logic                               wait_r, wait_nxt;
    logic [31:0]                        rdata_r, rdata_nxt;
    logic [31:0]                        prm_data_r, prm_data_nxt;
    logic                               prm_valid_r, prm_valid_nxt;
    logic                               prm_pend_r;
    logic [odt_pkg::PTR_W-1:0]          prm_addr_r;
    logic [odt_pkg::PTR_W-1:0]          ptr_r;
    logic                               align_err_r;
    logic [7:0]                         len_r [odt_pkg::NUM_SEQ];
    logic [odt_pkg::NUM_SEQ-1:0]        pres_r;
    logic [odt_pkg::NUM_SEQ-1:0]        pres_w;
    logic [odt_pkg::NUM_SEQ-1:0]        bad_w;
    logic [odt_pkg::MASK_W-1:0]         mask_w [odt_pkg::NUM_SEQ];
    logic [31:0]                        mem_rdata;

    // bus decode
    wire         bus_req   = (avs_read_in || avs_write_in) && wait_r;
    wire         idle_free = (st_r == ST_IDLE) && !prm_pend_r;
    wire         take_bus  = idle_free && bus_req;
    wire         sel_hdr0  = (avs_address_in == odt_pkg::OFS_HDR0);
    wire         sel_hdr1  = (avs_address_in == odt_pkg::OFS_HDR1);
    wire         sel_stat  = (avs_address_in == odt_pkg::OFS_STAT);
    wire         sel_mask  = (avs_address_in == odt_pkg::OFS_MASK);
    wire         sel_tbl   = (avs_address_in[7:odt_pkg::TBL_SEL_LSB] == odt_pkg::OFS_TBL[7:odt_pkg::TBL_SEL_LSB]);
    wire [2:0]   bus_idx   = avs_address_in[4:2];
    wire         wr_ptr    = take_bus && avs_write_in && sel_hdr1;
    wire         wr_stat   = take_bus && avs_write_in && sel_stat;
    wire         wr_tbl    = take_bus && avs_write_in && sel_tbl;

    // parameter-space decode: table occupies eight dwords from the pointer
    wire [odt_pkg::PTR_W-1:0] prm_off = prm_addr_r - ptr_r;
    wire         prm_hit   = (prm_addr_r >= ptr_r) && (prm_off[odt_pkg::PTR_W-1:5] == 19'h00000);
    wire [2:0]   prm_idx   = prm_off[4:2];
    wire         take_prm  = (st_r == ST_IDLE) && prm_pend_r;

    // memory shares one address between the two requesters
    wire [2:0]   mem_addr  = take_prm ? prm_idx : bus_idx;

    // misaligned pointer byte 0 flags an error, low bits are dropped
    wire         ptr_misal = wr_ptr && avs_byteenable_in[0] && (avs_writedata_in[1:0] != 2'h0);

    // header, status and mask read dwords
    wire [31:0]  hdr0_w = {odt_pkg::HDR_TBL_LEN, odt_pkg::HDR_MAJOR,
                           odt_pkg::HDR_MINOR, odt_pkg::HDR_ID_LSB};
    wire [31:0]  hdr1_w = {odt_pkg::HDR_ID_MSB, ptr_r};
    wire [31:0]  stat_w = {23'h000000, align_err_r, bad_w, pres_w};
    wire [31:0]  mask_rd_w = {1'b0, mask_w[3], 1'b0, mask_w[2], 1'b0, mask_w[1], 1'b0, mask_w[0]};
    wire [31:0]  reg_rd_w = sel_hdr0 ? hdr0_w :
                            sel_hdr1 ? hdr1_w :
                            sel_stat ? stat_w :
                            sel_mask ? mask_rd_w : 32'h00000000;

    // table storage
    odt_table_mem u_mem (
        .sys_clk_in (sys_clk_in),
        .we_in      (wr_tbl),
        .be_in      (avs_byteenable_in),
        .wdata_in   (avs_writedata_in),
        .addr_in    (mem_addr),
        .rdata_out  (mem_rdata)
    );

    // per-entry count decode
    for (genvar g = 0; g < odt_pkg::NUM_SEQ; g++) begin : g_chk
        odt_seq_check u_chk (
            .len_in        (len_r[g]),
            .present_out   (pres_w[g]),
            .bad_len_out   (bad_w[g]),
            .byte_mask_out (mask_w[g])
        );
    end

    // transfer sequencing for bus and parameter port
    always_comb begin
        st_nxt        = st_r;
        wait_nxt      = wait_r;
        rdata_nxt     = rdata_r;
        prm_data_nxt  = prm_data_r;
        prm_valid_nxt = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (prm_pend_r) begin
                    if (prm_hit) begin
                        st_nxt = ST_PRM_RD;
                    end else begin
                        prm_data_nxt  = 32'h00000000;
                        prm_valid_nxt = 1'b1;
                    end
                end else if (bus_req) begin
                    if (avs_read_in && sel_tbl) begin
                        st_nxt = ST_BUS_RD;
                    end else begin
                        rdata_nxt = avs_read_in ? reg_rd_w : 32'h00000000;
                        wait_nxt  = 1'b0;
                        st_nxt    = ST_ACK;
                    end
                end
            end
            ST_BUS_RD: begin
                rdata_nxt = mem_rdata;
                wait_nxt  = 1'b0;
                st_nxt    = ST_ACK;
            end
            ST_PRM_RD: begin
                prm_data_nxt  = mem_rdata;
                prm_valid_nxt = 1'b1;
                st_nxt        = ST_IDLE;
            end
            ST_ACK: begin
                wait_nxt = 1'b1;
                st_nxt   = ST_IDLE;
            end
            default: begin
                wait_nxt = 1'b1;
                st_nxt   = ST_IDLE;
            end
        endcase
    end

    // state and answer registers
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_r        <= ST_IDLE;
            wait_r      <= 1'b1;
            rdata_r     <= 32'h00000000;
            prm_data_r  <= 32'h00000000;
            prm_valid_r <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            wait_r      <= wait_nxt;
            rdata_r     <= rdata_nxt;
            prm_data_r  <= prm_data_nxt;
            prm_valid_r <= prm_valid_nxt;
        end
    end

    // one pending parameter request; a new one while pending is dropped
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            prm_pend_r <= 1'b0;
            prm_addr_r <= 24'h000000;
        end else if (take_prm) begin
            prm_pend_r <= 1'b0;
        end else if (prm_rd_in && !prm_pend_r) begin
            prm_pend_r <= 1'b1;
            prm_addr_r <= prm_addr_in;
        end
    end

    // pointer register, kept dword-aligned
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ptr_r <= odt_pkg::PTR_RST;
        end else if (wr_ptr) begin
            for (int b = 0; b < 3; b++) begin
                if (avs_byteenable_in[b]) begin
                    ptr_r[b*8 +: 8] <= avs_writedata_in[b*8 +: 8];
                end
            end
            ptr_r[1:0] <= 2'h0;
        end
    end

    // sticky alignment error, a new error wins over a clear
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            align_err_r <= 1'b0;
        end else if (ptr_misal) begin
            align_err_r <= 1'b1;
        end else if (wr_stat && avs_byteenable_in[1] && avs_writedata_in[odt_pkg::STAT_ALIGN_BIT]) begin
            align_err_r <= 1'b0;
        end
    end

    // shadow of each entry count, taken from writes to even table dwords
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            for (int s = 0; s < odt_pkg::NUM_SEQ; s++) begin
                len_r[s] <= 8'h00;
            end
        end else if (wr_tbl && !bus_idx[0] && avs_byteenable_in[3]) begin
            len_r[bus_idx[2:1]] <= avs_writedata_in[odt_pkg::LEN_LSB +: 8];
        end
    end

    // registered presence view
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pres_r <= 4'h0;
        end else begin
            pres_r <= pres_w;
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata_out        = rdata_r;
    assign avs_waitrequest_out     = wait_r;
    assign prm_data_out            = prm_data_r;
    assign prm_valid_out           = prm_valid_r;
    assign table_start_pointer_out = ptr_r;
    assign seq_present_out         = pres_r;

    // header, pointer, table and parameter-map checks
    AST_HDR1_ID: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        take_bus && avs_read_in && sel_hdr1 |=> avs_readdata_out[31:24] == 8'hff && !avs_waitrequest_out)
        else $error("header dword two id byte wrong");

    AST_HDR0_ID: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        take_bus && avs_read_in && sel_hdr0 |=> avs_readdata_out[7:0] == 8'h0a)
        else $error("header dword one id byte wrong");

    AST_PTR_ALIGN: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        table_start_pointer_out[1:0] == 2'h0 && hdr1_w[23:0] == table_start_pointer_out)
        else $error("pointer not dword aligned");

    AST_PTR_WRITE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        wr_ptr && avs_byteenable_in == 4'hf |=> table_start_pointer_out == {$past(avs_writedata_in[23:2]), 2'h0})
        else $error("pointer write not applied");

    AST_ABSENT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        wr_tbl && bus_idx == 3'h0 && avs_byteenable_in[3] && avs_writedata_in[31:24] == 8'h00
        |=> ##1 !seq_present_out[0])
        else $error("zero count still present");

    AST_MASK: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        len_r[1] <= 8'h07 |-> mask_w[1] == 7'((8'h01 << len_r[1][2:0]) - 8'h01))
        else $error("byte mask does not follow count");

    AST_PRM_MAP: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        take_prm && prm_addr_r == ptr_r + 24'h000010 |-> mem_addr == 3'h4 ##1 st_r == ST_PRM_RD ##1 prm_valid_out)
        else $error("third entry not at dword five");

    AST_LEN_CAPTURE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        wr_tbl && bus_idx == 3'h6 && avs_byteenable_in[3] |=> len_r[3] == $past(avs_writedata_in[31:24]))
        else $error("fourth entry count not captured");

    // status, presence, mask, answer timing and header length checks
    AST_ALIGN_SET: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ptr_misal
        |=> stat_w[odt_pkg::STAT_ALIGN_BIT])
        else $error("misaligned pointer write not flagged");

    AST_PRES_FOLLOW: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        len_r[3] != 8'h00
        |=> seq_present_out[3])
        else $error("nonzero fourth count not shown present");

    AST_BAD_STAT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        take_bus && avs_read_in && sel_stat && len_r[1] > odt_pkg::MAX_LEN
        |=> avs_readdata_out[odt_pkg::STAT_BAD_LSB + 1] && !avs_waitrequest_out)
        else $error("over-long second count not flagged");

    AST_BAD_MASK: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        take_bus && avs_read_in && sel_mask && len_r[1] > odt_pkg::MAX_LEN
        |=> avs_readdata_out[14:8] == 7'h7f)
        else $error("over-long second count mask not full");

    AST_TBL_WAIT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        take_bus && avs_read_in && sel_tbl
        |=> avs_waitrequest_out ##1 !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("table read answer timing wrong");

    AST_HDR0_LEN: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        take_bus && avs_read_in && sel_hdr0
        |=> avs_readdata_out[31:24] == 8'h08)
        else $error("header table length not eight dwords");

endmodule : odt_seq_table

// ---- odt_host_model.sv ----
module odt_host_model (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    // control from the bench
    input  wire logic        start_in,
    input  wire logic [23:0] ptr_in,
    output logic             done_out,
    output logic             fault_out,
    // parameter read port
    output logic             prm_rd_out,
    output logic [23:0]      prm_addr_out,
    input  wire logic [31:0] prm_data_in,
    input  wire logic        prm_valid_in,
    // serial link: select, clock and one data line
    output logic             spi_cs_n_out,
    output logic             spi_sck_out,
    output logic             serial_in_line0_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] dw0;
    logic [31:0] dw1;

    // one parameter read, answer awaited under a bound
    task automatic fetch(input logic [23:0] addr, output logic [31:0] data);
        int n;
        prm_rd_out   <= 1'b1;
        prm_addr_out <= addr;
        @(posedge sys_clk_in);
        prm_rd_out <= 1'b0;
        data = 32'h0;
        for (n = 0; n < 10; n++) begin
            @(posedge sys_clk_in);
            if (prm_valid_in === 1'b1) break;
        end
        if (n == 10) fault_out <= 1'b1;
        else data = prm_data_in;
    endtask : fetch

    // msb first, clock idles low, one clock per bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            serial_in_line0_out <= b[i];
            @(posedge sys_clk_in);
            spi_sck_out <= 1'b1;
            @(posedge sys_clk_in);
            spi_sck_out <= 1'b0;
        end
    endtask : send_byte

    // fetch both dwords of an entry, then frame its bytes
    task automatic run_all();
        logic [7:0]  len;
        logic [55:0] seq;
        done_out <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            fetch(ptr_in + 24'(8 * s), dw0);
            fetch(ptr_in + 24'(8 * s + 4), dw1);
            len = dw0[31:24];
            seq = {dw0[23:0], dw1};
            if (len != 8'h00) begin
                spi_cs_n_out <= 1'b0;
                @(posedge sys_clk_in);
                for (int k = 0; k < len && k < 7; k++) send_byte(seq[55 - 8 * k -: 8]);
                @(posedge sys_clk_in);
                spi_cs_n_out        <= 1'b1;
                serial_in_line0_out <= ~serial_in_line0_out; // released line shows no stale bit
            end
        end
        done_out <= 1'b1;
    endtask : run_all

    // idle levels, then serve start requests
    initial begin
        done_out            = 1'b0;
        fault_out           = 1'b0;
        prm_rd_out          = 1'b0;
        prm_addr_out        = 24'h000000;
        spi_cs_n_out        = 1'b1;
        spi_sck_out         = 1'b0;
        serial_in_line0_out = 1'b1;
        forever begin
            @(posedge sys_clk_in);
            if (start_in === 1'b1 && sys_rst_in === 1'b0) run_all();
        end
    end
endmodule : odt_host_model

// ---- odt_seq_table_tb.sv ----
module odt_seq_table_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        prm_rd;
    logic [23:0] prm_addr;
    logic [31:0] prm_data;
    logic        prm_valid;
    logic [23:0] ptr;
    logic [3:0]  present;
    logic        start = 1'b0;
    logic        done;
    logic        fault;
    logic        cs_n;
    logic        sck;
    logic        sdat;
    logic [31:0] tbl [8] = '{32'h02a1b2c3, 32'hd4e5f6a7, 32'h00111111, 32'h22222222,
                             32'h07010203, 32'h04050607, 32'h019f8e7d, 32'h6c5b4a39};
    logic [7:0]  rx [$];
    logic [7:0]  exp_q [$];
    logic [7:0]  sh = 8'h00;
    logic [31:0] want;
    logic [55:0] v;
    int          nbits = 0;
    int          frames = 0;
    int          bad_frames = 0;
    int          error_cnt = 0;
    int          total_checks = 0;

    always #4 clk = ~clk;

    // device and host
    odt_seq_table dut (.sys_clk_in(clk), .sys_rst_in(rst), .avs_address_in(address), .avs_read_in(read),
        .avs_write_in(write), .avs_writedata_in(writedata), .avs_byteenable_in(byteenable),
        .avs_readdata_out(readdata), .avs_waitrequest_out(waitrequest), .prm_rd_in(prm_rd),
        .prm_addr_in(prm_addr), .prm_data_out(prm_data), .prm_valid_out(prm_valid),
        .table_start_pointer_out(ptr), .seq_present_out(present));
    odt_host_model host (.sys_clk_in(clk), .sys_rst_in(rst), .start_in(start), .ptr_in(ptr),
        .done_out(done), .fault_out(fault), .prm_rd_out(prm_rd), .prm_addr_out(prm_addr),
        .prm_data_in(prm_data), .prm_valid_in(prm_valid), .spi_cs_n_out(cs_n), .spi_sck_out(sck),
        .serial_in_line0_out(sdat));

    // link monitor: bytes, frames, bits per frame
    always @(posedge sck) begin
        sh = {sh[6:0], sdat};
        nbits++;
        if (nbits % 8 == 0) rx.push_back(sh);
    end
    always @(negedge cs_n) frames++;
    always @(posedge cs_n) if (nbits % 8 != 0) bad_frames++;

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        @(posedge clk);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        read       <= ~wr;
        write      <= wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (n == 20) begin
            error_cnt++;
            end_sim();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        check(q, exp);
    endtask : rd_chk

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // reset values of header and status
        rd_chk(odt_pkg::OFS_HDR0, 32'h0801000a);
        rd_chk(odt_pkg::OFS_HDR1, 32'hff000080);
        rd_chk(odt_pkg::OFS_STAT, 32'h00000000);
        check(32'(present), 32'h0);
        $display("test reset done");
        // pointer write: top byte read-only, low bits forced, misalignment flagged
        wr(odt_pkg::OFS_HDR1, 32'h12345673, 4'hf);
        rd_chk(odt_pkg::OFS_HDR1, 32'hff345670);
        rd_chk(odt_pkg::OFS_STAT, 32'h00000100);
        wr(odt_pkg::OFS_STAT, 32'h00000100, 4'h2);
        rd_chk(odt_pkg::OFS_STAT, 32'h00000000);
        wr(odt_pkg::OFS_HDR1, 32'h00000040, 4'hf);
        check(32'(ptr), 32'h40);
        $display("test pointer done");
        // table load, readback, masks, presence, ignored and unmapped places
        for (int i = 0; i < 8; i++) wr(odt_pkg::OFS_TBL + 8'(4 * i), tbl[i], 4'hf);
        for (int i = 0; i < 8; i++) rd_chk(odt_pkg::OFS_TBL + 8'(4 * i), tbl[i]);
        want = 32'h0;
        for (int s = 0; s < 4; s++) want |= ((32'h1 << tbl[2 * s][31:24]) - 32'h1) << (8 * s);
        rd_chk(odt_pkg::OFS_MASK, want);
        rd_chk(odt_pkg::OFS_STAT, 32'h0000000d);
        check(32'(present), 32'hd);
        wr(odt_pkg::OFS_HDR0, 32'h0, 4'hf);
        rd_chk(odt_pkg::OFS_HDR0, 32'h0801000a);
        wr(8'h10, 32'hffffffff, 4'hf);
        rd_chk(8'h10, 32'h0);
        $display("test table done");
        // host walks the table through the parameter port
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int n = 0; n < 3000 && done !== 1'b1; n++) @(posedge clk);
        check(32'(done), 32'h1);
        check(32'(fault), 32'h0);
        for (int s = 0; s < 4; s++) begin
            v = {tbl[2 * s][23:0], tbl[2 * s + 1]};
            for (int k = 0; k < tbl[2 * s][31:24]; k++) exp_q.push_back(v[55 - 8 * k -: 8]);
        end
        check(32'(rx.size()), 32'(exp_q.size()));
        for (int i = 0; i < exp_q.size() && i < rx.size(); i++) check(32'(rx[i]), 32'(exp_q[i]));
        check(32'(frames), 32'h3);
        check(32'(bad_frames), 32'h0);
        $display("test host walk done");
        // zero count and over-long count, then a second reset
        wr(odt_pkg::OFS_TBL, 32'h00a1b2c3, 4'hf);
        wr(odt_pkg::OFS_TBL + 8'h08, 32'h09000000, 4'hf);
        rd_chk(odt_pkg::OFS_STAT, 32'h0000002e);
        rd_chk(odt_pkg::OFS_MASK, 32'h017f7f00);
        check(32'(present), 32'he);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(32'(ptr), 32'h80);
        check(32'(present), 32'h0);
        rd_chk(odt_pkg::OFS_STAT, 32'h00000000);
        $display("test counts and reset done");
        end_sim();
    end
endmodule : odt_seq_table_tb
